// ==== rtl/evt_inject_pkg.sv ====
/*
  Shared constants and types for the event test injection block.
  Assumes a 16-bit register port with one-cycle read latency.
*/
package evt_inject_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] INJ_OFFSET      = 16'h0090;
  localparam logic [15:0] MASK_CRIT_OFF   = 16'h0094;
  localparam logic [15:0] MASK_STD_OFF    = 16'h0098;
  localparam logic [15:0] FLAG_OFF        = 16'h009C;
  localparam logic [15:0] CLEAR_OFF       = 16'h00A0;
  localparam logic [15:0] EVT_BITS_MASK   = 16'hFFC0;
  localparam logic [15:0] INJ_RESET       = 16'h0000;
  localparam logic [15:0] RDATA_UNMAPPED  = 16'h0000;

  // ==========================================================
  // event bit positions, bit 15 down to bit 6
  localparam int OVER_CURRENT_EVT_POS      = 15;
  localparam int OVER_VOLTAGE_EVT_POS      = 14;
  localparam int OVER_POWER_EVT_POS        = 13;
  localparam int UNDER_VOLTAGE_EVT_POS     = 12;
  localparam int OVER_FREQUENCY_EVT_POS    = 11;
  localparam int UNDER_FREQUENCY_EVT_POS   = 10;
  localparam int OVER_TEMPERATURE_EVT_POS  = 9;
  localparam int UNDER_TEMPERATURE_EVT_POS = 8;
  localparam int LINE_SAG_EVT_POS          = 7;
  localparam int LINE_SURGE_EVT_POS        = 6;

  // ==========================================================
  // register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // ==========================================================
  // whole module state
  typedef struct packed {
    logic [15:0] inj;
    logic [15:0] genuine;
    logic [15:0] mask_crit;
    logic [15:0] mask_std;
    logic [15:0] flags;
    logic [15:0] rdata;
    logic        crit_pin;
    logic        std_pin;
  } state_t;

  // ==========================================================
  // values after reset
  localparam logic [15:0] GENUINE_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET    = 16'h0000;
  localparam logic [15:0] FLAGS_RESET   = 16'h0000;
  localparam logic [15:0] RDATA_RESET   = 16'h0000;
  localparam state_t      STATE_RESET   = '{
    inj:       INJ_RESET,
    genuine:   GENUINE_RESET,
    mask_crit: MASK_RESET,
    mask_std:  MASK_RESET,
    flags:     FLAGS_RESET,
    rdata:     RDATA_RESET,
    crit_pin:  1'b0,
    std_pin:   1'b0
  };

endpackage

// ==== rtl/event_test_injection.sv ====
/*
  Event test injection and notification logic of a power monitor.
  Assumes genuine detections arrive as one-cycle synchronous pulses
  from the threshold comparators (trip_i, bits 15..6 used).
*/
// Operation
// [R1] 16-bit injection register at 0x0090, ten event bits, reset zero.
// [R2] a set injection bit raises its event without measured stimulus.
// [R3] injected events set flags and drive pins through the masks.
// [R4] writing zero drops injected events only; genuine ones stay.
// [R5] software clears genuine events through the separate clear register.
// [R6] bits 5 to 0 ignore writes and read zero.
// [R7] active event with standard mask set drives standard pin high.
// [R8] active state is latched genuine source OR injection bit.
`timescale 1ns/100ps

module event_test_injection
  import evt_inject_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] trip_i,
  output logic      [15:0] rdata_o,
  output logic      [15:0] event_flags_o,
  output logic             crit_notify_o,
  output logic             std_notify_o
);

  // ==========================================================
  // state
  state_t          st_reg;
  state_t          st_next;
  reg_req_t        req;
  logic     [15:0] active;
  logic     [15:0] clr;
  logic     [15:0] trip_evt;
  logic     [15:0] crit_hits;
  logic     [15:0] std_hits;
  logic            wr_inj;
  logic            wr_crit;
  logic            wr_std;
  logic            wr_clr;
  logic            rd_inj;
  logic            rd_crit;
  logic            rd_std;
  logic            rd_flag;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ==========================================================
  // helpers
  // address match on a request
  function automatic logic hit(input reg_req_t r, input logic [15:0] off);
    hit = (r.addr == off);
  endfunction

  // keep only the ten implemented event bits
  function automatic logic [15:0] evt_only(input logic [15:0] v);
    evt_only = v & EVT_BITS_MASK;
  endfunction

  // one genuine latch bit: a new trip beats a clear in the same cycle
  function automatic logic latch_bit(input logic held,
                                     input logic clear,
                                     input logic trip);
    latch_bit = (held & ~clear) | trip;
  endfunction

  // a pin is high while any routed event is active
  function automatic logic notify(input logic [15:0] hits);
    notify = |evt_only(hits);
  endfunction

  // ==========================================================
  // address decode
  assign wr_inj   = req.wr && hit(req, INJ_OFFSET);
  assign wr_crit  = req.wr && hit(req, MASK_CRIT_OFF);
  assign wr_std   = req.wr && hit(req, MASK_STD_OFF);
  assign wr_clr   = req.wr && hit(req, CLEAR_OFF);
  assign rd_inj   = req.rd && hit(req, INJ_OFFSET);
  assign rd_crit  = req.rd && hit(req, MASK_CRIT_OFF);
  assign rd_std   = req.rd && hit(req, MASK_STD_OFF);
  assign rd_flag  = req.rd && hit(req, FLAG_OFF);
  assign trip_evt = evt_only(trip_i);

  // ==========================================================
  // next state
  always_comb
  begin
    st_next   = st_reg;
    clr       = 16'h0000;
    active    = 16'h0000;
    crit_hits = 16'h0000;
    std_hits  = 16'h0000;
    // [R5] genuine clear path
    if (wr_clr)
    begin
      clr = evt_only(req.wdata);
    end
    // [R1] injection write
    // [R6] low bits dropped
    if (wr_inj)
    begin
      st_next.inj = evt_only(req.wdata);
    end
    if (wr_crit)
    begin
      st_next.mask_crit = evt_only(req.wdata);
    end
    if (wr_std)
    begin
      st_next.mask_std = evt_only(req.wdata);
    end
    // [R4] genuine latch untouched by injection writes
    // only the clear register drops it, and a trip wins over a clear
    st_next.genuine[OVER_CURRENT_EVT_POS] =
      latch_bit(st_reg.genuine[OVER_CURRENT_EVT_POS],
                clr[OVER_CURRENT_EVT_POS],
                trip_evt[OVER_CURRENT_EVT_POS]);

    st_next.genuine[OVER_VOLTAGE_EVT_POS] =
      latch_bit(st_reg.genuine[OVER_VOLTAGE_EVT_POS],
                clr[OVER_VOLTAGE_EVT_POS],
                trip_evt[OVER_VOLTAGE_EVT_POS]);

    st_next.genuine[OVER_POWER_EVT_POS] =
      latch_bit(st_reg.genuine[OVER_POWER_EVT_POS],
                clr[OVER_POWER_EVT_POS],
                trip_evt[OVER_POWER_EVT_POS]);

    st_next.genuine[UNDER_VOLTAGE_EVT_POS] =
      latch_bit(st_reg.genuine[UNDER_VOLTAGE_EVT_POS],
                clr[UNDER_VOLTAGE_EVT_POS],
                trip_evt[UNDER_VOLTAGE_EVT_POS]);

    st_next.genuine[OVER_FREQUENCY_EVT_POS] =
      latch_bit(st_reg.genuine[OVER_FREQUENCY_EVT_POS],
                clr[OVER_FREQUENCY_EVT_POS],
                trip_evt[OVER_FREQUENCY_EVT_POS]);

    st_next.genuine[UNDER_FREQUENCY_EVT_POS] =
      latch_bit(st_reg.genuine[UNDER_FREQUENCY_EVT_POS],
                clr[UNDER_FREQUENCY_EVT_POS],
                trip_evt[UNDER_FREQUENCY_EVT_POS]);

    st_next.genuine[OVER_TEMPERATURE_EVT_POS] =
      latch_bit(st_reg.genuine[OVER_TEMPERATURE_EVT_POS],
                clr[OVER_TEMPERATURE_EVT_POS],
                trip_evt[OVER_TEMPERATURE_EVT_POS]);

    st_next.genuine[UNDER_TEMPERATURE_EVT_POS] =
      latch_bit(st_reg.genuine[UNDER_TEMPERATURE_EVT_POS],
                clr[UNDER_TEMPERATURE_EVT_POS],
                trip_evt[UNDER_TEMPERATURE_EVT_POS]);

    st_next.genuine[LINE_SAG_EVT_POS] =
      latch_bit(st_reg.genuine[LINE_SAG_EVT_POS],
                clr[LINE_SAG_EVT_POS],
                trip_evt[LINE_SAG_EVT_POS]);

    st_next.genuine[LINE_SURGE_EVT_POS] =
      latch_bit(st_reg.genuine[LINE_SURGE_EVT_POS],
                clr[LINE_SURGE_EVT_POS],
                trip_evt[LINE_SURGE_EVT_POS]);

    // [R8] active is genuine OR injected
    // [R2] an injected bit needs no measured stimulus
    active[OVER_CURRENT_EVT_POS] =
      st_next.genuine[OVER_CURRENT_EVT_POS] |
      st_next.inj[OVER_CURRENT_EVT_POS];
    active[OVER_VOLTAGE_EVT_POS] =
      st_next.genuine[OVER_VOLTAGE_EVT_POS] |
      st_next.inj[OVER_VOLTAGE_EVT_POS];
    active[OVER_POWER_EVT_POS] =
      st_next.genuine[OVER_POWER_EVT_POS] |
      st_next.inj[OVER_POWER_EVT_POS];
    active[UNDER_VOLTAGE_EVT_POS] =
      st_next.genuine[UNDER_VOLTAGE_EVT_POS] |
      st_next.inj[UNDER_VOLTAGE_EVT_POS];
    active[OVER_FREQUENCY_EVT_POS] =
      st_next.genuine[OVER_FREQUENCY_EVT_POS] |
      st_next.inj[OVER_FREQUENCY_EVT_POS];
    active[UNDER_FREQUENCY_EVT_POS] =
      st_next.genuine[UNDER_FREQUENCY_EVT_POS] |
      st_next.inj[UNDER_FREQUENCY_EVT_POS];
    active[OVER_TEMPERATURE_EVT_POS] =
      st_next.genuine[OVER_TEMPERATURE_EVT_POS] |
      st_next.inj[OVER_TEMPERATURE_EVT_POS];
    active[UNDER_TEMPERATURE_EVT_POS] =
      st_next.genuine[UNDER_TEMPERATURE_EVT_POS] |
      st_next.inj[UNDER_TEMPERATURE_EVT_POS];
    active[LINE_SAG_EVT_POS] =
      st_next.genuine[LINE_SAG_EVT_POS] |
      st_next.inj[LINE_SAG_EVT_POS];
    active[LINE_SURGE_EVT_POS] =
      st_next.genuine[LINE_SURGE_EVT_POS] |
      st_next.inj[LINE_SURGE_EVT_POS];

    // masks take effect in the cycle they are written
    crit_hits[OVER_CURRENT_EVT_POS] =
      active[OVER_CURRENT_EVT_POS] &
      st_next.mask_crit[OVER_CURRENT_EVT_POS];
    std_hits[OVER_CURRENT_EVT_POS] =
      active[OVER_CURRENT_EVT_POS] &
      st_next.mask_std[OVER_CURRENT_EVT_POS];

    crit_hits[OVER_VOLTAGE_EVT_POS] =
      active[OVER_VOLTAGE_EVT_POS] &
      st_next.mask_crit[OVER_VOLTAGE_EVT_POS];
    std_hits[OVER_VOLTAGE_EVT_POS] =
      active[OVER_VOLTAGE_EVT_POS] &
      st_next.mask_std[OVER_VOLTAGE_EVT_POS];

    crit_hits[OVER_POWER_EVT_POS] =
      active[OVER_POWER_EVT_POS] &
      st_next.mask_crit[OVER_POWER_EVT_POS];
    std_hits[OVER_POWER_EVT_POS] =
      active[OVER_POWER_EVT_POS] &
      st_next.mask_std[OVER_POWER_EVT_POS];

    crit_hits[UNDER_VOLTAGE_EVT_POS] =
      active[UNDER_VOLTAGE_EVT_POS] &
      st_next.mask_crit[UNDER_VOLTAGE_EVT_POS];
    std_hits[UNDER_VOLTAGE_EVT_POS] =
      active[UNDER_VOLTAGE_EVT_POS] &
      st_next.mask_std[UNDER_VOLTAGE_EVT_POS];

    crit_hits[OVER_FREQUENCY_EVT_POS] =
      active[OVER_FREQUENCY_EVT_POS] &
      st_next.mask_crit[OVER_FREQUENCY_EVT_POS];
    std_hits[OVER_FREQUENCY_EVT_POS] =
      active[OVER_FREQUENCY_EVT_POS] &
      st_next.mask_std[OVER_FREQUENCY_EVT_POS];

    crit_hits[UNDER_FREQUENCY_EVT_POS] =
      active[UNDER_FREQUENCY_EVT_POS] &
      st_next.mask_crit[UNDER_FREQUENCY_EVT_POS];
    std_hits[UNDER_FREQUENCY_EVT_POS] =
      active[UNDER_FREQUENCY_EVT_POS] &
      st_next.mask_std[UNDER_FREQUENCY_EVT_POS];

    crit_hits[OVER_TEMPERATURE_EVT_POS] =
      active[OVER_TEMPERATURE_EVT_POS] &
      st_next.mask_crit[OVER_TEMPERATURE_EVT_POS];
    std_hits[OVER_TEMPERATURE_EVT_POS] =
      active[OVER_TEMPERATURE_EVT_POS] &
      st_next.mask_std[OVER_TEMPERATURE_EVT_POS];

    crit_hits[UNDER_TEMPERATURE_EVT_POS] =
      active[UNDER_TEMPERATURE_EVT_POS] &
      st_next.mask_crit[UNDER_TEMPERATURE_EVT_POS];
    std_hits[UNDER_TEMPERATURE_EVT_POS] =
      active[UNDER_TEMPERATURE_EVT_POS] &
      st_next.mask_std[UNDER_TEMPERATURE_EVT_POS];

    crit_hits[LINE_SAG_EVT_POS] =
      active[LINE_SAG_EVT_POS] &
      st_next.mask_crit[LINE_SAG_EVT_POS];
    std_hits[LINE_SAG_EVT_POS] =
      active[LINE_SAG_EVT_POS] &
      st_next.mask_std[LINE_SAG_EVT_POS];

    crit_hits[LINE_SURGE_EVT_POS] =
      active[LINE_SURGE_EVT_POS] &
      st_next.mask_crit[LINE_SURGE_EVT_POS];
    std_hits[LINE_SURGE_EVT_POS] =
      active[LINE_SURGE_EVT_POS] &
      st_next.mask_std[LINE_SURGE_EVT_POS];

    // [R3] flags and pins follow the active state of either source
    st_next.flags    = active;
    st_next.crit_pin = notify(crit_hits);
    // [R7] standard pin high when masked event active
    st_next.std_pin  = notify(std_hits);

    // [R6] unimplemented bits and idle cycles read zero
    st_next.rdata = RDATA_UNMAPPED;
    if (req.rd)
    begin
      unique case (1'b1)
        rd_inj:  st_next.rdata = st_reg.inj;
        rd_crit: st_next.rdata = st_reg.mask_crit;
        rd_std:  st_next.rdata = st_reg.mask_std;
        rd_flag: st_next.rdata = st_reg.flags;
        default: st_next.rdata = RDATA_UNMAPPED;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= STATE_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata_o       = st_reg.rdata;
  assign event_flags_o = st_reg.flags;
  assign crit_notify_o = st_reg.crit_pin;
  assign std_notify_o  = st_reg.std_pin;

endmodule

// ==== verif/eti_props.sv ====
/* event injection checker
   sees only the top module ports */
`timescale 1ns/100ps
module eti_props import evt_inject_pkg::*;
(
  input wire logic        clk_i, rst_n_i, wr_i, rd_i,
  input wire logic        crit_notify_o, std_notify_o,
  input wire logic [15:0] addr_i, wdata_i, trip_i,
  input wire logic [15:0] rdata_o, event_flags_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ===
  // subset checks (inj, trip, hold): every source bit must show as a flag; then low-bit, idle and pin checks
  property p_inj;
    wr_i && addr_i == INJ_OFFSET |=>
      &(event_flags_o | ~($past(wdata_i) & EVT_BITS_MASK));
  endproperty
  property p_trip;
    1 |=> &(event_flags_o | ~($past(trip_i) & EVT_BITS_MASK));
  endproperty
  property p_hold;
    !wr_i |=> &(event_flags_o | ~$past(event_flags_o));
  endproperty
  property p_unimp;
    {rdata_o[5:0], event_flags_o[5:0]} == 12'h000;
  endproperty
  property p_idle;
    !rd_i |=> rdata_o == 16'h0000;
  endproperty
  property p_crit;
    crit_notify_o |-> event_flags_o != 16'h0000;
  endproperty
  property p_std;
    std_notify_o |-> event_flags_o != 16'h0000;
  endproperty
  a_inj: assert property (p_inj) else $error("inj lost");
  a_trip: assert property (p_trip) else $error("trip lost");
  a_hold: assert property (p_hold) else $error("flag drop");
  a_unimp: assert property (p_unimp) else $error("low bits");
  a_idle: assert property (p_idle) else $error("rdata idle");
  a_crit: assert property (p_crit) else $error("crit");
  a_std: assert property (p_std) else $error("std");
  c_inj: cover property (wr_i && addr_i == INJ_OFFSET);
  c_std: cover property ($rose(std_notify_o));
  c_crit: cover property ($rose(crit_notify_o));
endmodule
bind event_test_injection eti_props u_props (.*);

// ==== verif/tb_event_test_injection.sv ====
/* random bench for event_test_injection
   drives every input port itself */
`timescale 1ns/100ps
module tb_event_test_injection import evt_inject_pkg::*;;
  logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
  logic crit_notify_o, std_notify_o;
  logic [15:0] addr_i = 0, wdata_i = 0, trip_i = 0, rdata_o;
  logic [15:0] event_flags_o, g, w, t, ms, mc, r;
  int n_fail = 0, num_checks = 0;
  event_test_injection dut_u (.*);
  initial forever #5 clk_i = ~clk_i;
  // ===
  task automatic chk(logic [15:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [15:0] a, d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'h1};
    @(posedge clk_i);
    wr_i <= 1'h0;
    #1;
  endtask
  task automatic rd(logic [15:0] a);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'h1};
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 r = rdata_o;
  endtask
  function automatic logic [15:0] pin(logic [15:0] m);
    return {15'h0, |((g | w) & m & EVT_BITS_MASK)};
  endfunction
  task automatic final_report;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // sized far above the ~350 cycles the tests need
  initial
  begin
    #50000;
    n_fail++;
    final_report;
  end
  initial
  begin
    void'($urandom(65330));
    g = 16'h0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rd(INJ_OFFSET);
    chk(r, INJ_RESET);
    for (int k = 0; k < 20; k++)
    begin
      {w, ms} = $urandom;
      {t, mc} = $urandom & $urandom;
      if (k == 0)
        w = 16'hFFFF;
      wr(MASK_CRIT_OFF, mc);
      wr(MASK_STD_OFF, ms);
      @(posedge clk_i);
      trip_i <= t;
      @(posedge clk_i);
      trip_i <= 16'h0;
      g = (g | t) & EVT_BITS_MASK;
      wr(INJ_OFFSET, w);
      w = w & EVT_BITS_MASK;
      chk(event_flags_o, g | w);
      chk({15'h0, crit_notify_o}, pin(mc));
      chk({15'h0, std_notify_o}, pin(ms));
      rd(INJ_OFFSET);
      chk(r, w);
      rd(FLAG_OFF);
      chk(r, g | w);
      rd(MASK_STD_OFF);
      chk(r, ms & EVT_BITS_MASK);
      wr(INJ_OFFSET, 16'h0);
      w = 16'h0;
      chk(event_flags_o, g);
      chk({15'h0, crit_notify_o}, pin(mc));
      chk({15'h0, std_notify_o}, pin(ms));
      if (k % 4 == 3)
      begin
        wr(CLEAR_OFF, 16'hFFFF);
        g = 16'h0;
        chk(event_flags_o, g);
      end
      $display("test %0d done", k);
    end
    rd(16'h0002);
    chk(r, RDATA_UNMAPPED);
    final_report;
  end
endmodule
